/* File: logic/bbpc_cfg_if.sv */
// bbpc_cfg_if: carries register contents and pin levels to the pin decoder and
// its decoded results back to the register bank.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface bbpc_cfg_if;
    logic [7:0] mode_cfg;
    logic [7:0] pin_enable_sel;
    logic [4:0] dvs_code;
    logic [7:0] pins;
    logic [2:0] regulator_sequence_field;
    logic [1:0] regulator_enable_field;
    logic fast_mode;
    logic pin_control_active;
    logic pin_enable_request;
    logic dvs_active;
    logic [1:0] dvs_index;

    modport regs (
        output mode_cfg, pin_enable_sel, dvs_code, pins,
        output regulator_sequence_field, regulator_enable_field,
        input fast_mode, pin_control_active, pin_enable_request, dvs_active, dvs_index
    );
    modport dec (
        input mode_cfg, pin_enable_sel, dvs_code, pins,
        input regulator_sequence_field, regulator_enable_field,
        output fast_mode, pin_control_active, pin_enable_request, dvs_active, dvs_index
    );
endinterface

/* File: logic/bbpc_pin_decode.sv */
// bbpc_pin_decode: combinational decode of fast-mode source, pin enable and the
// voltage-scaling pin pair from register contents and synchronised pin levels.
// Assumes pins are already synchronised; results are registered by the caller.
`timescale 1ns/10ps
module bbpc_pin_decode (
    // register side
    bbpc_cfg_if.dec cfg
);
    import bbpc_pkg::*;

    logic [4:0] pair_code;
    logic pair_hit;
    logic [1:0] pair_index;

    // fast mode source: register bit or multipurpose pin 1
    always_comb begin
        if (cfg.mode_cfg[BBPC_BIT_PIN_DRIVEN_FAST_SELECT]) begin
            cfg.fast_mode = cfg.pins[BBPC_FAST_PIN];
        end else begin
            cfg.fast_mode = cfg.mode_cfg[BBPC_BIT_PRETRIGGER_FAST_MODE];
        end
    end

    // pin selections count only in the pin-controlled sequence and enable codes
    always_comb begin
        cfg.pin_control_active = (cfg.regulator_sequence_field == BBPC_SEQ_PIN_CONTROLLED) &&
            (cfg.regulator_enable_field == BBPC_EN_PIN_CONTROLLED);
        cfg.pin_enable_request = cfg.pin_control_active &&
            (|(cfg.pins & cfg.pin_enable_sel));
    end

    // walk pairs lo<hi in ascending order; code n picks the n-th pair
    always_comb begin
        pair_code = 5'h00;
        pair_hit = 1'b0;
        pair_index = 2'h0;
        for (int lo = 0; lo < BBPC_NUM_PINS - 1; lo++) begin
            for (int hi = lo + 1; hi < BBPC_NUM_PINS; hi++) begin
                pair_code = pair_code + 5'h01;
                if (pair_code == cfg.dvs_code) begin
                    pair_hit = 1'b1;
                    pair_index = {cfg.pins[lo], cfg.pins[hi]};
                end
            end
        end
        // zero and codes past the last pair never hit, so scaling stays off
        cfg.dvs_active = pair_hit && (cfg.dvs_code != BBPC_DVS_DISABLED);
        cfg.dvs_index = pair_hit ? pair_index : 2'h0;
    end
endmodule

/* File: logic/bbpc_pkg.sv */
// bbpc_pkg: register map, field positions, reset values and serial-port constants
// for the buck-boost pin-control configuration block.
// Assumes an 8-bit register address space behind a two-wire serial slave.
package bbpc_pkg;
    // register offsets
    localparam logic [7:0] BBPC_OFS_MODE_CFG = 8'h44;
    localparam logic [7:0] BBPC_OFS_PIN_ENABLE_SEL = 8'h45;
    localparam logic [7:0] BBPC_OFS_VOLTAGE_PIN_PAIR = 8'h46;

    // reset values
    localparam logic [7:0] BBPC_RST_MODE_CFG = 8'h00;
    localparam logic [7:0] BBPC_RST_PIN_ENABLE_SEL = 8'h00;
    localparam logic [7:0] BBPC_RST_VOLTAGE_PIN_PAIR = 8'h00;

    // writable bit masks, reserved bits read as zero
    localparam logic [7:0] BBPC_MASK_MODE_CFG = 8'h7f;
    localparam logic [7:0] BBPC_MASK_PIN_ENABLE_SEL = 8'hff;
    localparam logic [7:0] BBPC_MASK_VOLTAGE_PIN_PAIR = 8'h1f;
    localparam logic [7:0] BBPC_UNMAPPED_READ = 8'h00;

    // mode configuration field positions
    localparam int BBPC_BIT_ADAPTIVE_CURRENT_DISABLE = 6;
    localparam int BBPC_BIT_PRETRIGGER_FAST_MODE = 5;
    localparam int BBPC_BIT_ZERO_CROSS_COMPARATOR_DISABLE = 4;
    localparam int BBPC_BIT_SWITCH_SIZE_HALVE = 3;
    localparam int BBPC_BIT_PIN_DRIVEN_FAST_SELECT = 2;
    localparam int BBPC_LSB_HIGH_FREQ_THRESHOLD = 0;
    localparam int BBPC_W_HIGH_FREQ_THRESHOLD = 2;

    // pin control gating codes and widths
    localparam int BBPC_NUM_PINS = 8;
    localparam int BBPC_W_DVS_CODE = 5;
    localparam int BBPC_FAST_PIN = 1;
    localparam logic [2:0] BBPC_SEQ_PIN_CONTROLLED = 3'h7;
    localparam logic [1:0] BBPC_EN_PIN_CONTROLLED = 2'h2;
    localparam logic [4:0] BBPC_DVS_DISABLED = 5'h00;

    // serial slave: 7-bit device address default (arbitrary value)
    localparam logic [6:0] BBPC_DEV_ADDR_DEFAULT = 7'h3c;
    localparam logic [3:0] BBPC_BITS_PER_BYTE = 4'h8;
endpackage

/* File: logic/bbpc_top.sv */
// bbpc_top: buck-boost pin-control register bank behind a two-wire serial slave,
// with synchronised multipurpose pins and registered control outputs.
// Assumes open-drain bus pins resolved outside and pins asynchronous to sys_clk.
//
// Overview of operation
// - bit 6 set disables adaptive current
// - bit 5 selects pretrigger fast mode
// - bit 4 set disables zero-cross comparator
// - bit 3 set forces switch size halving
// - bit 2 makes pin 1 drive fast mode
// - bits 1:0 pick high-frequency threshold
// - selected pin n becomes an enable source
// - selections count only with sequence 111, enable 10
// - regulator enable is OR of selected pins
// - pair code zero disables voltage scaling
// - codes 1 to 28 select ascending ordered pin pair
// - selected pin levels index four alternate voltages
`timescale 1ns/10ps
module bbpc_top #(
    parameter logic [6:0] DEV_ADDR = bbpc_pkg::BBPC_DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial register port, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // multipurpose pins and regulator sequencing
    input wire logic [7:0] multipurpose_pin,
    input wire logic [2:0] regulator_sequence_field,
    input wire logic [1:0] regulator_enable_field,
    // converter controls
    output logic adaptive_current_disable,
    output logic fast_mode_enable,
    output logic zero_cross_comparator_disable,
    output logic switch_size_halve,
    output logic [1:0] high_freq_threshold_select,
    output logic pin_control_active,
    output logic regulator_pin_enable,
    output logic dynamic_voltage_scaling_active,
    output logic [1:0] alternate_voltage_index
);
    import bbpc_pkg::*;

    typedef enum logic [7:0] {
        BBPC_ST_IDLE = 8'h01,
        BBPC_ST_ADDR = 8'h02,
        BBPC_ST_ACK_OUT = 8'h04,
        BBPC_ST_REG = 8'h08,
        BBPC_ST_WDATA = 8'h10,
        BBPC_ST_RDATA = 8'h20,
        BBPC_ST_ACK_IN = 8'h40,
        BBPC_ST_RLOAD = 8'h80
    } bbpc_state_t;

    bbpc_state_t state_q;
    bbpc_state_t after_ack_q;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [7:0] pin_sync1_q;
    logic [7:0] pin_sync2_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic sda_oe_q;
    logic [7:0] mode_cfg_q;
    logic [7:0] pin_enable_sel_q;
    logic [7:0] voltage_pin_pair_q;
    logic wr_stb;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_byte;
    logic fast_mode_q;
    logic pin_control_active_q;
    logic regulator_pin_enable_q;
    logic dvs_active_q;
    logic [1:0] dvs_index_q;

    bbpc_cfg_if cfg_bus ();

    // two-stage synchronisers; the edge detectors look only at stage two
    // reset to the idle-high level so release never looks like a start or a fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // multipurpose pins come from outside the clock domain
    // cleared on reset; a pin already high shows up two edges after release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_sync1_q <= 8'h00;
            pin_sync2_q <= 8'h00;
        end else begin
            pin_sync1_q <= multipurpose_pin;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // bus events, start and stop seen while the clock line is high
    assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
    assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
    assign bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign bus_stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
    assign wr_stb = (state_q == BBPC_ST_WDATA) && scl_fall && (bit_cnt_q == BBPC_BITS_PER_BYTE);

    // read mux; unmapped offsets read zero, reserved bits already held at zero
    always_comb begin
        unique case (ptr_q)
            BBPC_OFS_MODE_CFG: rd_byte = mode_cfg_q;
            BBPC_OFS_PIN_ENABLE_SEL: rd_byte = pin_enable_sel_q;
            BBPC_OFS_VOLTAGE_PIN_PAIR: rd_byte = voltage_pin_pair_q;
            default: rd_byte = BBPC_UNMAPPED_READ;
        endcase
    end

    // serial slave: sample on rising clock, drive data and ack after falling clock
    // start and stop win over any state, so a cut frame always resyncs
    // a non-matching address parks in idle until the next start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= BBPC_ST_IDLE;
            after_ack_q <= BBPC_ST_REG;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (bus_start) begin
            state_q <= BBPC_ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= BBPC_ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                BBPC_ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                BBPC_ST_ADDR, BBPC_ST_REG, BBPC_ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BBPC_BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q != BBPC_ST_ADDR) begin
                            sda_oe_q <= 1'b1;
                            after_ack_q <= BBPC_ST_WDATA;
                            state_q <= BBPC_ST_ACK_OUT;
                        end else if (shift_q[7:1] == DEV_ADDR) begin
                            rw_q <= shift_q[0];
                            sda_oe_q <= 1'b1;
                            after_ack_q <= BBPC_ST_REG;
                            state_q <= BBPC_ST_ACK_OUT;
                        end else begin
                            state_q <= BBPC_ST_IDLE; // another device is addressed
                        end
                    end
                end
                BBPC_ST_ACK_OUT: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            shift_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            state_q <= BBPC_ST_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= after_ack_q;
                        end
                    end
                end
                BBPC_ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BBPC_BITS_PER_BYTE) begin
                        sda_oe_q <= 1'b0; // release for the master's ack
                        bit_cnt_q <= 4'h0;
                        state_q <= BBPC_ST_ACK_IN;
                    end else if (scl_fall) begin
                        sda_oe_q <= ~shift_q[6];
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
                BBPC_ST_ACK_IN: begin
                    if (scl_rise) begin
                        state_q <= sda_sync_q[1] ? BBPC_ST_IDLE : BBPC_ST_RLOAD;
                    end
                end
                BBPC_ST_RLOAD: begin
                    if (scl_fall) begin
                        shift_q <= rd_byte;
                        sda_oe_q <= ~rd_byte[7];
                        state_q <= BBPC_ST_RDATA;
                    end
                end
                default: begin
                    state_q <= BBPC_ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // register pointer: set by the offset byte, steps after each written byte and each acknowledged read byte
    // eight-bit pointer wraps with no range check; unmapped offsets read zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ptr_q <= 8'h00;
        end else if (state_q == BBPC_ST_REG && scl_fall && bit_cnt_q == BBPC_BITS_PER_BYTE) begin
            ptr_q <= shift_q;
        end else if (wr_stb) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (state_q == BBPC_ST_ACK_IN && scl_rise && !sda_sync_q[1]) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // register bank; writes to unmapped offsets are dropped
    // reserved bits are masked on the way in so readback needs no extra logic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_cfg_q <= BBPC_RST_MODE_CFG;
            pin_enable_sel_q <= BBPC_RST_PIN_ENABLE_SEL;
            voltage_pin_pair_q <= BBPC_RST_VOLTAGE_PIN_PAIR;
        end else if (wr_stb) begin
            if (ptr_q == BBPC_OFS_MODE_CFG) begin
                mode_cfg_q <= shift_q & BBPC_MASK_MODE_CFG;
            end
            if (ptr_q == BBPC_OFS_PIN_ENABLE_SEL) begin
                pin_enable_sel_q <= shift_q & BBPC_MASK_PIN_ENABLE_SEL;
            end
            if (ptr_q == BBPC_OFS_VOLTAGE_PIN_PAIR) begin
                voltage_pin_pair_q <= shift_q & BBPC_MASK_VOLTAGE_PIN_PAIR;
            end
        end
    end

    // decoder inputs
    assign cfg_bus.mode_cfg = mode_cfg_q;
    assign cfg_bus.pin_enable_sel = pin_enable_sel_q;
    assign cfg_bus.dvs_code = voltage_pin_pair_q[BBPC_W_DVS_CODE-1:0];
    assign cfg_bus.pins = pin_sync2_q;
    assign cfg_bus.regulator_sequence_field = regulator_sequence_field;
    assign cfg_bus.regulator_enable_field = regulator_enable_field;

    bbpc_pin_decode u_decode (
        .cfg(cfg_bus)
    );

    // registered decode results keep the outputs glitch free for the analogue side
    // pins reach these outputs three edges after a change at the pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fast_mode_q <= 1'b0;
            pin_control_active_q <= 1'b0;
            regulator_pin_enable_q <= 1'b0;
            dvs_active_q <= 1'b0;
            dvs_index_q <= 2'h0;
        end else begin
            fast_mode_q <= cfg_bus.fast_mode;
            pin_control_active_q <= cfg_bus.pin_control_active;
            regulator_pin_enable_q <= cfg_bus.pin_enable_request;
            dvs_active_q <= cfg_bus.dvs_active;
            dvs_index_q <= cfg_bus.dvs_index;
        end
    end

    // direct mode bits come straight from the configuration flops
    // no decode on these, so they follow a write on the same edge
    assign adaptive_current_disable = mode_cfg_q[BBPC_BIT_ADAPTIVE_CURRENT_DISABLE];
    assign zero_cross_comparator_disable =
        mode_cfg_q[BBPC_BIT_ZERO_CROSS_COMPARATOR_DISABLE];
    assign switch_size_halve = mode_cfg_q[BBPC_BIT_SWITCH_SIZE_HALVE];
    assign high_freq_threshold_select =
        mode_cfg_q[BBPC_LSB_HIGH_FREQ_THRESHOLD +: BBPC_W_HIGH_FREQ_THRESHOLD];
    assign fast_mode_enable = fast_mode_q;
    assign pin_control_active = pin_control_active_q;
    assign regulator_pin_enable = regulator_pin_enable_q;
    assign dynamic_voltage_scaling_active = dvs_active_q;
    assign alternate_voltage_index = dvs_index_q;
    assign sda_oe = sda_oe_q;
    // open drain: only ever pulls low, so the data level is a constant
    assign sda_out = 1'b0;
endmodule

/* File: verification/bbpc_host_model.sv */
// bbpc_host_model: host side of the two-wire register port, open drain.
// Assumes the bench resolves the data wire with a pull-up into sda_line.
`timescale 1ns/10ps
module bbpc_host_model #(
    parameter logic [6:0] ADDR = bbpc_pkg::BBPC_DEV_ADDR_DEFAULT
) (
    // clock
    input wire logic sys_clk,
    // bus lines
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    import bbpc_pkg::*;
    // both lines released at start, pull-ups make them idle high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // six cycles a phase, above the four-cycle minimum
    task automatic half();
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic start();
        half();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
    // data moves only mid-low so it never races the clock edge
    task automatic xfer_bit(input logic b, output logic r);
        half();
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        r = sda_line;
        scl = 1'b0;
    endtask
    // msb first; ninth bit released for ack, or driven high as nack
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], rx[i]);
        end
        xfer_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer_byte({ADDR, 1'b0}, rx, a0);
        xfer_byte(ofs, rx, a1);
        xfer_byte(val, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // single-byte read, last byte not acknowledged
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        xfer_byte({ADDR, 1'b0}, rx, a0);
        xfer_byte(ofs, rx, a1);
        start();
        xfer_byte({ADDR, 1'b1}, rx, a2);
        xfer_byte(8'hff, val, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* File: verification/bbpc_monitor.sv */
// bbpc_monitor: gating, pin-path and serial-drive checks on bbpc_top ports.
// Assumes a single sys_clk domain and the active-high asynchronous rst.
`timescale 1ns/10ps
module bbpc_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial port
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // pins and sequencing
    input wire logic [7:0] multipurpose_pin,
    input wire logic [2:0] regulator_sequence_field,
    input wire logic [1:0] regulator_enable_field,
    // decoded controls
    input wire logic fast_mode_enable,
    input wire logic pin_control_active,
    input wire logic regulator_pin_enable,
    input wire logic dynamic_voltage_scaling_active,
    input wire logic [1:0] alternate_voltage_index
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // gate follows the sequencing inputs one edge later, not right after reset
    a_gate_one_edge: assert property (!$past(rst) |->
        pin_control_active == ($past(regulator_sequence_field) == 3'h7
        && $past(regulator_enable_field) == 2'h2)) else $error("gate flag wrong");
    a_enable_needs_gate: assert property (
        !pin_control_active && !$past(pin_control_active) |-> !regulator_pin_enable)
        else $error("pin enable without gate");
    a_enable_needs_pin: assert property (
        regulator_pin_enable |-> $past(multipurpose_pin, 3) != 8'h00)
        else $error("pin enable with all pins low");
    a_index_idle_zero: assert property (
        !dynamic_voltage_scaling_active |-> alternate_voltage_index == 2'b00)
        else $error("index set while scaling off");
    a_index_needs_pin: assert property (
        alternate_voltage_index != 2'b00 |-> $past(multipurpose_pin, 3) != 8'h00)
        else $error("index set with all pins low");
    // acknowledge only starts once the clock line has been low a while
    a_ack_after_fall: assert property (
        $rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data drive rose too early");
    // a change while the clock is high would look like start or stop
    a_oe_clock_low: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data drive changed with clock high");
    a_drive_zero: assert property (sda_out == 1'b0)
        else $error("open-drain value not low");

    // main scenarios reached
    c_pin_enable: cover property ($rose(regulator_pin_enable));
    c_index_low_pin: cover property (alternate_voltage_index == 2'b10);
    c_index_both: cover property (alternate_voltage_index == 2'b11);
    c_fast_mode: cover property ($rose(fast_mode_enable));
endmodule

bind bbpc_top bbpc_monitor mon (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .multipurpose_pin(multipurpose_pin),
    .regulator_sequence_field(regulator_sequence_field),
    .regulator_enable_field(regulator_enable_field),
    .fast_mode_enable(fast_mode_enable), .pin_control_active(pin_control_active),
    .regulator_pin_enable(regulator_pin_enable),
    .dynamic_voltage_scaling_active(dynamic_voltage_scaling_active),
    .alternate_voltage_index(alternate_voltage_index)
);

/* File: verification/tb_buck_boost_pin_control_cfg.sv */
// tb_buck_boost_pin_control_cfg: mode, pin-enable and pin-pair checks over the serial port.
// Assumes a pull-up on the data wire and the host model as the only bus master.
`timescale 1ns/10ps
module tb_buck_boost_pin_control_cfg;
    import bbpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] mpin = 8'h00;
    logic [2:0] seq_f = 3'h0;
    logic [1:0] en_f = 2'h0;
    logic scl, sda_drv, sda_out, sda_oe, ok;
    logic acd, fme, zcd, ssh, pca, rpe, dva;
    logic [1:0] hft, avi;
    logic [7:0] rd, code;
    logic [7:0] modes [8] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h01, 8'h02, 8'h03};
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // open-drain wire: low if either party pulls
    wire logic sda_line = sda_drv & ~(sda_oe & ~sda_out);
    wire logic [7:0] mode_seen = {1'b0, acd, fme, zcd, ssh, 1'b0, hft};
    wire logic [7:0] gate_seen = {6'h0, pca, rpe};
    wire logic [7:0] dvs_seen = {5'h0, dva, avi};

    bbpc_top dut (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .multipurpose_pin(mpin),
        .regulator_sequence_field(seq_f), .regulator_enable_field(en_f),
        .adaptive_current_disable(acd), .fast_mode_enable(fme),
        .zero_cross_comparator_disable(zcd), .switch_size_halve(ssh),
        .high_freq_threshold_select(hft), .pin_control_active(pca),
        .regulator_pin_enable(rpe), .dynamic_voltage_scaling_active(dva),
        .alternate_voltage_index(avi)
    );
    bbpc_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    // 50 ns period
    always #25 sys_clk = ~sys_clk;
    // hang guard, well above the roughly 40k cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.write_reg(a, v, ok);
        check({7'h0, ok}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rd, ok);
        check({7'h0, ok}, 8'h01);
        check(rd, exp);
    endtask
    // tasks end on a falling edge, so pins change off the sampling edge
    task automatic pins(input logic [7:0] p);
        mpin = p;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(mode_seen | gate_seen | dvs_seen, 8'h00);
        rd_chk(BBPC_OFS_MODE_CFG, 8'h00);
        rd_chk(BBPC_OFS_PIN_ENABLE_SEL, 8'h00);
        rd_chk(BBPC_OFS_VOLTAGE_PIN_PAIR, 8'h00);
        foreach (modes[i]) begin
            wr(BBPC_OFS_MODE_CFG, modes[i]);
            check(mode_seen, modes[i]);
        end
        // pin 1 overrides the register fast bit both ways
        wr(BBPC_OFS_MODE_CFG, 8'h24);
        pins(8'h02);
        check({7'h0, fme}, 8'h01);
        pins(8'h00);
        check({7'h0, fme}, 8'h00);
        wr(BBPC_OFS_MODE_CFG, 8'h04);
        pins(8'h02);
        check({7'h0, fme}, 8'h01);
        wr(BBPC_OFS_MODE_CFG, 8'h00);
        check({7'h0, fme}, 8'h00);
        wr(BBPC_OFS_MODE_CFG, 8'h20);
        check({7'h0, fme}, 8'h01);
        wr(BBPC_OFS_MODE_CFG, 8'hff);
        rd_chk(BBPC_OFS_MODE_CFG, 8'h7f);
        seq_f = 3'h7;
        en_f = 2'h2;
        for (int n = 0; n < 8; n++) begin
            wr(BBPC_OFS_PIN_ENABLE_SEL, 8'h01 << n);
            pins(~(8'h01 << n));
            check(gate_seen, 8'h02);
            pins(8'h01 << n);
            check(gate_seen, 8'h03);
        end
        wr(BBPC_OFS_PIN_ENABLE_SEL, 8'h81);
        rd_chk(BBPC_OFS_PIN_ENABLE_SEL, 8'h81);
        pins(8'h7e);
        check(gate_seen, 8'h02);
        pins(8'h80);
        check(gate_seen, 8'h03);
        en_f = 2'h1;
        pins(8'h81);
        check(gate_seen, 8'h00);
        en_f = 2'h2;
        seq_f = 3'h6;
        pins(8'h81);
        check(gate_seen, 8'h00);
        seq_f = 3'h7;
        pins(8'h81);
        check(gate_seen, 8'h03);
        // every pair code, pins walked in ascending order
        code = 8'h00;
        for (int lo = 0; lo < 8; lo++) begin
            for (int hi = lo + 1; hi < 8; hi++) begin
                code++;
                wr(BBPC_OFS_VOLTAGE_PIN_PAIR, code);
                pins(8'h01 << lo);
                check(dvs_seen, 8'h06);
                pins(8'h01 << hi);
                check(dvs_seen, 8'h05);
                pins((8'h01 << lo) | (8'h01 << hi));
                check(dvs_seen, 8'h07);
                pins(~((8'h01 << lo) | (8'h01 << hi)));
                check(dvs_seen, 8'h04);
            end
        end
        wr(BBPC_OFS_VOLTAGE_PIN_PAIR, 8'h00);
        pins(8'hff);
        check(dvs_seen, 8'h00);
        // reserved codes, upper bits written too and dropped
        for (int c = 29; c < 32; c++) begin
            wr(BBPC_OFS_VOLTAGE_PIN_PAIR, 8'he0 | c[7:0]);
            check(dvs_seen, 8'h00);
            rd_chk(BBPC_OFS_VOLTAGE_PIN_PAIR, c[7:0]);
        end
        // mid-run reset: registers clear, sequencing gate stays live
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(mode_seen | dvs_seen, 8'h00);
        check(gate_seen, 8'h02);
        rd_chk(BBPC_OFS_VOLTAGE_PIN_PAIR, 8'h00);
        wr(8'h50, 8'h5a);
        rd_chk(8'h50, 8'h00);
        print_verdict();
    end
endmodule
